// File: src/status_output_pin_select.sv
// status output pin selection for three status pins
`timescale 1ns/1ps
module status_output_pin_select (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic [7:0] pin_a_config_in,
   input  wire logic [7:0] pin_b_config_in,
   input  wire logic [7:0] pin_c_config_in,
   input  wire logic       config_write_in,
   input  wire logic       sleep_in,
   input  wire logic       chip_ready_low_in,
   input  wire logic       rx_fifo_at_thr_in,
   input  wire logic       rx_fifo_empty_in,
   input  wire logic       rx_packet_end_in,
   input  wire logic       tx_fifo_at_thr_in,
   input  wire logic       tx_fifo_full_in,
   input  wire logic       fifo_overflow_in,
   input  wire logic       fifo_underflow_in,
   input  wire logic       fifo_flush_in,
   input  wire logic       sync_event_in,
   input  wire logic       packet_end_in,
   input  wire logic       addr_fail_in,
   input  wire logic       crc_ok_event_in,
   input  wire logic       rx_first_read_in,
   input  wire logic [7:0] preamble_quality_level_in,
   input  wire logic [7:0] preamble_quality_threshold_in,
   input  wire logic       signal_below_cca_in,
   input  wire logic       synth_lock_in,
   input  wire logic       serial_clock_in,
   output logic [2:0]      status_pin_out,
   output logic [2:0]      status_pin_oe_out,
   output logic            temp_sensor_out
);
   logic [7:0] cfg [3];
   logic [6:0] div_count;
   logic       div_clk;
   logic       rx_pkt_flag;
   logic       tx_full_flag;
   logic       ovf_flag;
   logic       unf_flag;
   logic       sync_flag;
   logic       crc_flag;
   logic       sleep_hold;
   logic [7:0] cfg_in [3];

   assign cfg_in[0] = pin_a_config_in;
   assign cfg_in[1] = pin_b_config_in;
   assign cfg_in[2] = pin_c_config_in;

   // configuration latched on host write
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cfg[0] <= status_pin_pkg::PIN_A_RESET; // R4
         cfg[1] <= status_pin_pkg::PIN_B_RESET; // R3
         cfg[2] <= status_pin_pkg::PIN_C_RESET;
      end else if (config_write_in) begin
         cfg[0] <= cfg_in[0]; // R4
         cfg[1] <= cfg_in[1];
         cfg[2] <= cfg_in[2];
      end
   end

   // crystal clock divided by 192
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         div_count <= 7'h00;
         div_clk   <= 1'b0;
      end else if (div_count == status_pin_pkg::HALF_DIV_M1) begin
         div_count <= 7'h00;
         div_clk   <= ~div_clk; // R4
      end else begin
         div_count <= div_count + 7'h01;
      end
   end

   // sticky status flags; set wins over clear
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rx_pkt_flag  <= 1'b0;
         tx_full_flag <= 1'b0;
         ovf_flag     <= 1'b0;
         unf_flag     <= 1'b0;
         sync_flag    <= 1'b0;
         crc_flag     <= 1'b0;
      end else begin
         if (rx_fifo_at_thr_in || rx_packet_end_in)
            rx_pkt_flag <= 1'b1; // R11
         else if (rx_fifo_empty_in)
            rx_pkt_flag <= 1'b0; // R11
         if (tx_fifo_full_in)
            tx_full_flag <= 1'b1; // R13
         else if (!tx_fifo_at_thr_in)
            tx_full_flag <= 1'b0; // R13
         if (fifo_overflow_in)
            ovf_flag <= 1'b1; // R14
         else if (fifo_flush_in)
            ovf_flag <= 1'b0; // R14
         if (fifo_underflow_in)
            unf_flag <= 1'b1; // R15
         else if (fifo_flush_in)
            unf_flag <= 1'b0; // R15
         if (sync_event_in)
            sync_flag <= 1'b1; // R16
         else if (packet_end_in || addr_fail_in || fifo_overflow_in || fifo_underflow_in)
            sync_flag <= 1'b0; // R16
         if (crc_ok_event_in)
            crc_flag <= 1'b1; // R17
         else if (rx_first_read_in)
            crc_flag <= 1'b0; // R17
      end
   end

   // sleep forcing lasts from sleep entry until chip ready low goes low
   always_ff @(posedge clk_in) begin
      if (rst_in)
         sleep_hold <= 1'b0;
      else if (sleep_in)
         sleep_hold <= 1'b1; // R7
      else if (!chip_ready_low_in)
         sleep_hold <= 1'b0; // R7
   end

   always_ff @(posedge clk_in) begin
      if (rst_in)
         temp_sensor_out <= 1'b0;
      else
         temp_sensor_out <= (cfg[0] == status_pin_pkg::TEMP_SENSOR); // R5
   end

   function automatic logic select_signal(input logic [5:0] sel);
      logic s;
      s = 1'b0;
      unique case (sel)
         status_pin_pkg::SEL_RX_THR:  s = rx_fifo_at_thr_in; // R10
         status_pin_pkg::SEL_RX_PKT:  s = rx_pkt_flag; // R11
         status_pin_pkg::SEL_TX_THR:  s = tx_fifo_at_thr_in; // R12
         status_pin_pkg::SEL_TX_FULL: s = tx_full_flag; // R13
         status_pin_pkg::SEL_OVF:     s = ovf_flag; // R14
         status_pin_pkg::SEL_UNF:     s = unf_flag; // R15
         status_pin_pkg::SEL_SYNC:    s = sync_flag; // R16
         status_pin_pkg::SEL_CRC_OK:  s = crc_flag; // R17
         status_pin_pkg::SEL_PQT:     s = (preamble_quality_level_in > preamble_quality_threshold_in); // R18
         status_pin_pkg::SEL_CCA:     s = signal_below_cca_in; // R19
         status_pin_pkg::SEL_LOCK:    s = synth_lock_in; // R20
         status_pin_pkg::SEL_SER_CLK: s = serial_clock_in; // R21 R22
         status_pin_pkg::SEL_HIGH:    s = 1'b1;
         status_pin_pkg::SEL_DIV_CLK: s = div_clk; // R4
         default:                     s = 1'b0;
      endcase
      return s;
   endfunction

   // one output stage per pin
   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : g_pin // R1
         logic [5:0] sel;
         logic       inv;
         logic       forced;
         assign sel    = cfg[i][status_pin_pkg::SEL_MSB:0];
         assign inv    = cfg[i][status_pin_pkg::INVERT_BIT];
         assign forced = sleep_hold && (sel < status_pin_pkg::SEL_SLEEP_MIN); // R6 R8
         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               status_pin_out[i]    <= 1'b0;
               status_pin_oe_out[i] <= (i != 1); // R3
            end else begin
               status_pin_oe_out[i] <= (sel != status_pin_pkg::SEL_HIZ) &&
                                       !(i == 0 && cfg[0] == status_pin_pkg::TEMP_SENSOR); // R9 R5
               if (forced)
                  status_pin_out[i] <= (i == 1) ? ~inv : inv; // R6
               else
                  status_pin_out[i] <= select_signal(sel) ^ inv; // R23
            end
         end
      end
   endgenerate

   AST_HIZ_CODE: assert property (@(posedge clk_in) disable iff (rst_in)
      (!config_write_in && cfg[1][5:0] == 6'h2E) |=> !status_pin_oe_out[1]) // R9
      else $error("pin b driven with high impedance code");
   AST_SLEEP_A: assert property (@(posedge clk_in) disable iff (rst_in)
      (sleep_hold && cfg[0][5:0] < 6'h20) |=> status_pin_out[0] == $past(cfg[0][6])) // R6
      else $error("pin a not forced in sleep");
   AST_SLEEP_B: assert property (@(posedge clk_in) disable iff (rst_in)
      (sleep_hold && cfg[1][5:0] < 6'h20) |=> status_pin_out[1] == !$past(cfg[1][6])) // R6
      else $error("pin b not forced to complement in sleep");
   AST_HOLD_END: assert property (@(posedge clk_in) disable iff (rst_in)
      (!sleep_in && !chip_ready_low_in) |=> !sleep_hold) // R7
      else $error("sleep hold not released");
   AST_OVF_STICKY: assert property (@(posedge clk_in) disable iff (rst_in)
      (ovf_flag && !fifo_flush_in) |=> ovf_flag) // R14
      else $error("overflow flag dropped");
   AST_UNF_SET: assert property (@(posedge clk_in) disable iff (rst_in)
      fifo_underflow_in |=> unf_flag) // R15
      else $error("underflow flag not set");
   AST_CRC_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in)
      (rx_first_read_in && !crc_ok_event_in) |=> !crc_flag) // R17
      else $error("crc flag not cleared on read");
   AST_RX_THR: assert property (@(posedge clk_in) disable iff (rst_in)
      (!config_write_in && !sleep_hold && cfg[2][6:0] == 7'h00) |=> status_pin_out[2] == $past(rx_fifo_at_thr_in)) // R10
      else $error("pin c does not follow rx threshold");
   AST_DIV_PERIOD: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(div_clk) |=> div_clk [*8]) // R4
      else $error("divided clock high phase too short");

   // sleep entry walk: hold set one edge later, pin forced the edge after
   sequence seq_sleep_enter_a;
      sleep_in && !sleep_hold && !config_write_in && cfg[0][5:0] < 6'h20;
   endsequence

   sequence seq_pin_a_forced;
      ##1 status_pin_out[0] == $past(cfg[0][6], 2);
   endsequence

   AST_SLEEP_WALK: assert property (@(posedge clk_in) disable iff (rst_in) // R6
      seq_sleep_enter_a |=> seq_pin_a_forced)
      else $error("pin a not forced two edges after sleep entry");

   AST_OVF_SET: assert property (@(posedge clk_in) disable iff (rst_in) // R14
      fifo_overflow_in |=> ovf_flag)
      else $error("overflow flag not set");

   AST_OVF_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in) // R14
      (fifo_flush_in && !fifo_overflow_in) |=> !ovf_flag)
      else $error("overflow flag not cleared by flush");

   AST_UNF_HOLD: assert property (@(posedge clk_in) disable iff (rst_in) // R15
      (unf_flag && !fifo_flush_in) |=> unf_flag)
      else $error("underflow flag dropped");

   AST_UNF_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in) // R15
      (fifo_flush_in && !fifo_underflow_in) |=> !unf_flag)
      else $error("underflow flag not cleared by flush");

   AST_RX_PKT_SET: assert property (@(posedge clk_in) disable iff (rst_in) // R11
      (rx_fifo_at_thr_in || rx_packet_end_in) |=> rx_pkt_flag)
      else $error("rx packet flag not set");

   AST_RX_PKT_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in) // R11
      (rx_fifo_empty_in && !rx_fifo_at_thr_in && !rx_packet_end_in) |=> !rx_pkt_flag)
      else $error("rx packet flag not cleared on empty");

   AST_TX_FULL_SET: assert property (@(posedge clk_in) disable iff (rst_in) // R13
      tx_fifo_full_in |=> tx_full_flag)
      else $error("tx full flag not set");

   AST_TX_FULL_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in) // R13
      (!tx_fifo_full_in && !tx_fifo_at_thr_in) |=> !tx_full_flag)
      else $error("tx full flag not cleared below threshold");

   AST_SYNC_SET: assert property (@(posedge clk_in) disable iff (rst_in) // R16
      sync_event_in |=> sync_flag)
      else $error("packet frame flag not set");

   AST_SYNC_END: assert property (@(posedge clk_in) disable iff (rst_in) // R16
      (!sync_event_in && packet_end_in) |=> !sync_flag)
      else $error("packet frame flag not cleared at end");

   AST_SYNC_ABORT: assert property (@(posedge clk_in) disable iff (rst_in) // R16
      (!sync_event_in && (addr_fail_in || fifo_overflow_in || fifo_underflow_in)) |=> !sync_flag)
      else $error("packet frame flag not cleared on abort");

   AST_CRC_SET: assert property (@(posedge clk_in) disable iff (rst_in) // R17
      crc_ok_event_in |=> crc_flag)
      else $error("crc flag not set");

   AST_CRC_HOLD: assert property (@(posedge clk_in) disable iff (rst_in) // R17
      (crc_flag && !rx_first_read_in) |=> crc_flag)
      else $error("crc flag dropped before read");

   AST_SLEEP_C: assert property (@(posedge clk_in) disable iff (rst_in) // R6
      (sleep_hold && cfg[2][5:0] < 6'h20) |=> status_pin_out[2] == $past(cfg[2][6]))
      else $error("pin c not forced in sleep");

   AST_HOLD_SET: assert property (@(posedge clk_in) disable iff (rst_in) // R7
      sleep_in |=> sleep_hold)
      else $error("sleep hold not set");

   AST_HOLD_PERSIST: assert property (@(posedge clk_in) disable iff (rst_in) // R7
      (sleep_hold && chip_ready_low_in) |=> sleep_hold)
      else $error("sleep hold released while chip not ready");

   AST_HIZ_C: assert property (@(posedge clk_in) disable iff (rst_in) // R9
      (cfg[2][5:0] == 6'h2E) |=> !status_pin_oe_out[2])
      else $error("pin c driven with high impedance code");

   AST_DRIVE_B: assert property (@(posedge clk_in) disable iff (rst_in) // R1
      (cfg[1][5:0] != 6'h2E) |=> status_pin_oe_out[1])
      else $error("pin b not driven");

   AST_TEMP_MODE: assert property (@(posedge clk_in) disable iff (rst_in) // R5
      (cfg[0] == 8'h80) |=> (temp_sensor_out && !status_pin_oe_out[0]))
      else $error("temperature mode not applied");

   AST_HIGH_KEPT: assert property (@(posedge clk_in) disable iff (rst_in) // R8
      (cfg[0] == 8'h2F) |=> status_pin_out[0])
      else $error("high code not kept");

   AST_TX_THR_C: assert property (@(posedge clk_in) disable iff (rst_in) // R12
      (!sleep_hold && cfg[2][6:0] == 7'h02) |=> status_pin_out[2] == $past(tx_fifo_at_thr_in))
      else $error("pin c does not follow tx threshold");

   AST_LOCK_INV_C: assert property (@(posedge clk_in) disable iff (rst_in) // R20 R23
      (!sleep_hold && cfg[2][6:0] == 7'h4A) |=> status_pin_out[2] == !$past(synth_lock_in))
      else $error("pin c does not show inverted lock");

   AST_PQT_C: assert property (@(posedge clk_in) disable iff (rst_in) // R18
      (!sleep_hold && cfg[2][6:0] == 7'h08) |=>
         status_pin_out[2] == $past(preamble_quality_level_in > preamble_quality_threshold_in))
      else $error("pin c does not show preamble quality");

   AST_CCA_C: assert property (@(posedge clk_in) disable iff (rst_in) // R19
      (!sleep_hold && cfg[2][6:0] == 7'h09) |=> status_pin_out[2] == $past(signal_below_cca_in))
      else $error("pin c does not show clear channel");

   AST_SER_CLK_C: assert property (@(posedge clk_in) disable iff (rst_in) // R21 R22
      (!sleep_hold && cfg[2][6:0] == 7'h0B) |=> status_pin_out[2] == $past(serial_clock_in))
      else $error("pin c does not show serial clock");

   AST_DIV_LOW: assert property (@(posedge clk_in) disable iff (rst_in) // R4
      $fell(div_clk) |=> !div_clk [*8])
      else $error("divided clock low phase too short");
endmodule // status_output_pin_select

// File: src/status_pin_pkg.sv
// constants for the status output pin selection logic
// What this block does
// (R1) three output pins, each with its own select field choosing an internal signal
// (R2) host trusts pin b signal only while spi chip select is high
// (R3) pin b defaults to high impedance after power-on reset
// (R4) pin a defaults to crystal clock divided by 192; host select replaces it
// (R5) value 0x80 in pin a config selects the analog temperature output
// (R6) in sleep, codes below 0x20 force pins a,c to invert, pin b to complement
// (R7) forced sleep levels hold until chip ready low goes low
// (R8) codes 0x20 and above keep working during sleep
// (R9) code 0x2E gives high impedance in every state
// (R10) code 0x00 high while rx fifo fill at or above threshold
// (R11) code 1 sets on rx threshold or packet end, clears on rx fifo empty
// (R12) code 0x02 high while tx fifo fill at or above threshold
// (R13) code 0x03 sets on tx fifo full, clears below tx threshold
// (R14) code 0x04 sets on overflow, holds until fifo flushed
// (R15) code 0x05 sets on underflow, holds until fifo flushed
// (R16) code 0x06 frames packet, ends early on address fail or fifo error
// (R17) code 0x07 sets on good crc packet, clears on first rx byte read
// (R18) code 0x08 high when preamble quality level exceeds threshold
// (R19) code 0x09 high while signal strength below clear channel threshold
// (R20) code 10 outputs synthesizer lock detector
// (R21) code 11 outputs serial clock; rx data launched on its falling edge
// (R22) in tx, data sampled on rising edge of the serial clock
// (R23) invert bit complements the selected signal
package status_pin_pkg;
   localparam logic [7:0] PIN_A_RESET   = 8'h3F;
   localparam logic [7:0] PIN_B_RESET   = 8'h2E;
   localparam logic [7:0] PIN_C_RESET   = 8'h29;
   localparam logic [7:0] TEMP_SENSOR   = 8'h80;
   localparam int         INVERT_BIT    = 6;
   localparam int         SEL_MSB       = 5;
   localparam logic [5:0] SEL_RX_THR    = 6'h00;
   localparam logic [5:0] SEL_RX_PKT    = 6'h01;
   localparam logic [5:0] SEL_TX_THR    = 6'h02;
   localparam logic [5:0] SEL_TX_FULL   = 6'h03;
   localparam logic [5:0] SEL_OVF       = 6'h04;
   localparam logic [5:0] SEL_UNF       = 6'h05;
   localparam logic [5:0] SEL_SYNC      = 6'h06;
   localparam logic [5:0] SEL_CRC_OK    = 6'h07;
   localparam logic [5:0] SEL_PQT       = 6'h08;
   localparam logic [5:0] SEL_CCA       = 6'h09;
   localparam logic [5:0] SEL_LOCK      = 6'h0A;
   localparam logic [5:0] SEL_SER_CLK   = 6'h0B;
   localparam logic [5:0] SEL_SLEEP_MIN = 6'h20;
   localparam logic [5:0] SEL_HIZ       = 6'h2E;
   localparam logic [5:0] SEL_HIGH      = 6'h2F;
   localparam logic [5:0] SEL_DIV_CLK   = 6'h3F;
   localparam int         CLK_DIV       = 192;
   localparam int         HALF_DIV      = CLK_DIV / 2;
   localparam logic [6:0] HALF_DIV_M1   = 7'(HALF_DIV - 1);
endpackage

// File: bench/status_pin_host.sv
// host model that samples the three status pins
`timescale 1ns/1ps
module status_pin_host (
   input  wire logic       clk_in,
   input  wire logic       cs_high_in,
   input  wire logic [2:0] pin_in,
   input  wire logic [2:0] oe_in,
   output logic [2:0]      seen_out
);
   // a released pin shows no stable level, so the last value is flipped
   always_ff @(posedge clk_in) begin
      seen_out[0] <= oe_in[0] ? pin_in[0] : ~seen_out[0];
      seen_out[1] <= (oe_in[1] && cs_high_in) ? pin_in[1] : ~seen_out[1];
      seen_out[2] <= oe_in[2] ? pin_in[2] : ~seen_out[2];
   end
endmodule // status_pin_host

// File: bench/status_output_pin_select_tb.sv
// self-checking bench for the status pin selection block
`timescale 1ns/1ps
module status_output_pin_select_tb;
   logic       clk_in, rst_in, wr, slp, rdy_n, rxt, rxe, rxp, txt, txf, ovf, unf, fl, syn, pe, af, crc, rd;
   logic       cca, lk, sck, temp;
   logic [7:0] ca, cb, cc, pq, pt;
   logic [2:0] pin, oe, seen;
   int         fails, total_checks;
   status_output_pin_select u_status_output_pin_select (.clk_in(clk_in), .rst_in(rst_in),
      .pin_a_config_in(ca), .pin_b_config_in(cb), .pin_c_config_in(cc), .config_write_in(wr),
      .sleep_in(slp), .chip_ready_low_in(rdy_n), .rx_fifo_at_thr_in(rxt), .rx_fifo_empty_in(rxe),
      .rx_packet_end_in(rxp), .tx_fifo_at_thr_in(txt), .tx_fifo_full_in(txf), .fifo_overflow_in(ovf),
      .fifo_underflow_in(unf), .fifo_flush_in(fl), .sync_event_in(syn), .packet_end_in(pe),
      .addr_fail_in(af), .crc_ok_event_in(crc), .rx_first_read_in(rd), .preamble_quality_level_in(pq),
      .preamble_quality_threshold_in(pt), .signal_below_cca_in(cca), .synth_lock_in(lk),
      .serial_clock_in(sck), .status_pin_out(pin), .status_pin_oe_out(oe), .temp_sensor_out(temp));
   status_pin_host u_status_pin_host (.clk_in(clk_in), .cs_high_in(1'b1), .pin_in(pin), .oe_in(oe),
      .seen_out(seen));
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic cmp(logic [7:0] got, logic [7:0] exp, string m);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic chk(logic e);
      cmp(8'(seen[2]), 8'(e), "pin c level");
   endtask
   task automatic cfg(logic [7:0] a, logic [7:0] b, logic [7:0] c);
      {ca, cb, cc} = {a, b, c};
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
      tick(3);
   endtask
   task automatic pz(int w);
      {rxp, ovf, unf, fl, syn, pe, af, crc, rd} = 9'(1 << w);
      tick(1);
      {rxp, ovf, unf, fl, syn, pe, af, crc, rd} = 9'h000;
      tick(3);
   endtask
   task automatic t_div();
      int n;
      logic v;
      cmp(8'(oe), 8'h05, "reset enables");
      for (int k = 0; k < 2; k++) begin
         v = pin[0];
         n = 0;
         while (pin[0] === v && n < 300) begin
            tick(1);
            n++;
         end
      end
      cmp(8'(n), 8'h60, "divided clock half period");
      if (n >= 300) summarize();
      $display("test div done");
   endtask
   task automatic t_levels();
      logic [5:0] c [6] = '{6'h00, 6'h02, 6'h08, 6'h09, 6'h0A, 6'h0B};
      for (int i = 0; i < 12; i++) begin
         cfg(8'h3F, 8'h2E, {1'b0, i[0], c[i / 2]});
         {rxt, txt, cca, lk, sck} = 5'h1F;
         pq = 8'h06;
         tick(3);
         chk(~i[0]);
         {rxt, txt, cca, lk, sck} = 5'h00;
         pq = 8'h05;
         tick(3);
         chk(i[0]);
      end
      $display("test levels done");
   endtask
   task automatic t_sticky();
      logic [5:0] c [7] = '{6'h04, 6'h05, 6'h06, 6'h06, 6'h06, 6'h06, 6'h07};
      int s [7] = '{7, 6, 4, 4, 4, 4, 1};
      int r [7] = '{5, 5, 3, 2, 7, 6, 0};
      for (int i = 0; i < 7; i++) begin
         cfg(8'h3F, 8'h2E, {2'b00, c[i]});
         pz(s[i]);
         tick(4);
         chk(1'b1);
         pz(r[i]);
         chk(1'b0);
      end
      cfg(8'h3F, 8'h2E, 8'h03);
      {txt, txf} = 2'b11;
      tick(1);
      txf = 1'b0;
      tick(3);
      chk(1'b1);
      txt = 1'b0;
      tick(3);
      chk(1'b0);
      cfg(8'h3F, 8'h2E, 8'h01);
      pz(8);
      chk(1'b1);
      rxe = 1'b1;
      tick(3);
      chk(1'b0);
      rxe = 1'b0;
      $display("test sticky done");
   endtask
   task automatic t_sleep();
      cfg(8'h00, 8'h00, 8'h40);
      {rxt, slp, rdy_n} = 3'b111;
      tick(3);
      cmp(8'(pin), 8'h06, "forced sleep levels");
      slp = 1'b0;
      tick(3);
      cmp(8'(pin), 8'h06, "forced levels held");
      rdy_n = 1'b0;
      tick(3);
      cmp(8'(pin), 8'h03, "levels resumed");
      cfg(8'h2F, 8'h2E, 8'h40);
      {slp, rdy_n} = 2'b11;
      tick(3);
      cmp({7'h00, pin[0]}, 8'h01, "high code kept in sleep");
      cmp({7'h00, oe[1]}, 8'h00, "hi-z code in sleep");
      {slp, rdy_n, rxt} = 3'b000;
      cfg(8'h80, 8'h2E, 8'h40);
      cmp({6'h00, temp, oe[0]}, 8'h02, "temperature mode");
      $display("test sleep done");
   endtask
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   initial begin
      {wr, slp, rdy_n, rxt, rxe, txt, txf, cca, lk, sck} = 10'h000;
      {rxp, ovf, unf, fl, syn, pe, af, crc, rd} = 9'h000;
      {ca, cb, cc, pq, pt} = {8'h3F, 8'h2E, 8'h29, 8'h00, 8'h05};
      rst_in = 1'b1;
      tick(10);
      rst_in = 1'b0;
      t_div();
      t_levels();
      t_sticky();
      t_sleep();
      summarize();
   end
endmodule // status_output_pin_select_tb
